// file: design/sgl_glue.sv
// System glue logic: flush/init pulse generator, resume reset, gates.
// Assumes all pins arrive asynchronously and are synchronised here;
// open-drain pins leave the wire level to the pad (oe high = drive low).
//
// Operation
// - Flush edge, init low: flush pulse, init repulses
// - Flush edge, init high: flush, delayed init pulse
// - Flush request high: flush floats, init follows
// - Wrap low: flush edge ignored entirely
// - Pulse timing independent of input clock rate
// - Strap low means 66, high 33
// - Resume reset released 32 ms after supply
// - Drive LED low when any activity low
// - Two non-inverted copies of bus reset
// - Power good high when both inputs high
// - NAND, inverter and buffer gates
// - Out_a low when good and S3
// - Turn-on low when slot low, S3 high
// - Bias gate low while power good high
// - Display lines follow low side levels
// - Sync outputs copy sync inputs
// - Yellow and green LEDs float only when blink and S5
// - Latched backfeed set by cut, cleared S5
// - Latched backfeed stays low at power-up
`timescale 1ns/100ps
module sgl_glue
    import sgl_pkg::*;
#(
    parameter int unsigned RSM_CYC = RSM_DELAY_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_flush_request_in,
    input wire logic i_address_wrap_in,
    input wire logic i_init_in,
    input wire logic i_clk_rate_strap,
    input wire logic i_standby_5v_supply,
    input wire logic i_audio_enable_in,
    input wire logic i_pci_reset_in,
    input wire logic i_mute_in,
    input wire logic i_primary_drive_active,
    input wire logic i_secondary_drive_active,
    input wire logic i_scsi_drive_active,
    input wire logic i_front_panel_reset,
    input wire logic i_supply_power_good,
    input wire logic i_gate1_input_a,
    input wire logic i_gate1_input_b,
    input wire logic i_gate2_input,
    input wire logic i_gate3_input,
    input wire logic i_sleep_state3,
    input wire logic i_sleep_state5,
    input wire logic i_slot_occupied,
    input wire logic i_display_data_low_side,
    input wire logic i_display_clock_low_side,
    input wire logic i_horizontal_sync_in,
    input wire logic i_vertical_sync_in,
    input wire logic i_yellow_blink_in,
    input wire logic i_green_blink_in,
    output logic o_cpu_flush_oe,
    output logic o_firmware_hub_flush_oe,
    output logic o_init_out_oe,
    output logic o_resume_reset_out,
    output logic o_audio_reset_out,
    output logic o_audio_shutdown_out,
    output logic o_drive_activity_led_oe,
    output logic o_drive_reset_out,
    output logic o_buffered_bus_reset_out,
    output logic o_power_good_3v_out,
    output logic o_gate1_nand_out,
    output logic o_gate2_inverter_out,
    output logic o_gate3_buffer_out,
    output logic o_out_a_oe,
    output logic o_latched_backfeed_out,
    output logic o_supply_turn_on_oe,
    output logic o_clock_bias_gate_oe,
    output logic o_display_data_high_side,
    output logic o_display_clock_high_side,
    output logic o_horizontal_sync_out,
    output logic o_vertical_sync_out,
    output logic o_yellow_led_oe,
    output logic o_green_led_oe
);
    // ------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------
    // The sequencer runs on the system clock, so the strap is only registered
    // into strap_ff and drives nothing; both strap settings give identical times.
    localparam int unsigned T1_CYC = (T1_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned TU_CYC = (TU_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned GAP_CYC = T1_CYC - TU_CYC;
    localparam int unsigned INIT_CYC = 2 * TU_CYC;
    localparam int unsigned FAST_CLKS = T1_NS * CLK_IN_FAST_MHZ / 1000;
    localparam int unsigned SLOW_CLKS = T1_NS * CLK_IN_SLOW_MHZ / 1000;
    localparam logic [CNT_W-1:0] T1_LAST = CNT_W'(T1_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);
    localparam logic [RSM_W-1:0] RSM_LAST = RSM_W'(RSM_CYC - 1);

    if (TU_CYC < 1 || T1_CYC <= TU_CYC || INIT_CYC >= (1 << CNT_W)) begin : g_bad_t
        $error("sgl_glue: t and t1 counts out of range");
    end
    if (RSM_CYC < 2 || RSM_CYC >= (1 << RSM_W)) begin : g_bad_rsm
        $error("sgl_glue: resume delay out of range");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NSYNC = 26;
    logic [NSYNC-1:0] s;
    sgl_sync #(.WIDTH(NSYNC)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_async({i_flush_request_in, i_address_wrap_in, i_init_in, i_clk_rate_strap,
                  i_standby_5v_supply, i_audio_enable_in, i_pci_reset_in, i_mute_in,
                  i_primary_drive_active, i_secondary_drive_active,
                  i_scsi_drive_active, i_front_panel_reset, i_supply_power_good,
                  i_gate1_input_a, i_gate1_input_b, i_gate2_input, i_gate3_input,
                  i_sleep_state3, i_sleep_state5, i_slot_occupied,
                  i_display_data_low_side, i_display_clock_low_side,
                  i_horizontal_sync_in, i_vertical_sync_in, i_yellow_blink_in,
                  i_green_blink_in}),
        .o_sync(s)
    );
    logic fl_req, wrap, init_in, strap, stby, audio_enable_in, pci_rst, mute;
    logic pri_hd, sec_hd, scsi_hd, fp_rst, ps_good, g1a, g1b, g2i, g3i;
    logic slp3, slp5, slot, ddc_sda, ddc_scl, hs, vs, ylw_bl, grn_bl;
    assign {fl_req, wrap, init_in, strap, stby, audio_enable_in, pci_rst, mute,
            pri_hd, sec_hd, scsi_hd, fp_rst, ps_good, g1a, g1b, g2i, g3i,
            slp3, slp5, slot, ddc_sda, ddc_scl, hs, vs, ylw_bl, grn_bl} = s;

    // ------------------------------------------------------------
    // Flush / init pulse sequencer
    // ------------------------------------------------------------
    sgl_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic fl_req_d_ff, nxt_fl_req_d;
    logic init_pulse_ff, nxt_init_pulse;
    logic gap_ff, nxt_gap;
    logic strap_ff, nxt_strap;
    logic flush_edge;

    assign flush_edge = fl_req_d_ff & ~fl_req;

    // Sequence: flush low t1, init released at t1-t... modelled as
    // flush window of t1, then a gap of t1-t, then init low for 2*t.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_fl_req_d = fl_req;
        nxt_init_pulse = 1'b0;
        nxt_gap = gap_ff;
        nxt_strap = strap; // strap is sampled after reset release
        unique case (state_ff)
            SGL_IDLE: begin
                nxt_cnt = '0;
                if (flush_edge && wrap) begin
                    nxt_state = SGL_FLUSH;
                end // edge ignored with wrap low
            end
            SGL_FLUSH: begin
                if (cnt_ff == T1_LAST) begin
                    nxt_state = SGL_INIT;
                    nxt_cnt = '0;
                    nxt_gap = 1'b1;
                end
            end
            SGL_INIT: begin
                if (gap_ff) begin
                    if (cnt_ff == GAP_LAST) begin // delay t1-t
                        nxt_gap = 1'b0;
                        nxt_cnt = '0;
                        nxt_init_pulse = 1'b1;
                    end
                end else if (cnt_ff == INIT_LAST) begin // 2*t
                    nxt_state = SGL_IDLE;
                    nxt_cnt = '0;
                end else begin
                    nxt_init_pulse = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= SGL_IDLE;
            cnt_ff <= '0;
            fl_req_d_ff <= 1'b0; // Matches the synchroniser reset: no false edge
            init_pulse_ff <= 1'b0;
            gap_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fl_req_d_ff <= nxt_fl_req_d;
            init_pulse_ff <= nxt_init_pulse;
            gap_ff <= nxt_gap;
            strap_ff <= nxt_strap;
        end
    end

    // ------------------------------------------------------------
    // Resume reset delay
    // ------------------------------------------------------------
    logic [RSM_W-1:0] rsm_cnt_ff, nxt_rsm_cnt;
    logic rsm_ff, nxt_rsm;

    // Supply fall reasserts at once; rise restarts the 32 ms count
    always_comb begin
        nxt_rsm_cnt = rsm_cnt_ff;
        nxt_rsm = rsm_ff;
        if (!stby) begin
            nxt_rsm_cnt = '0;
            nxt_rsm = 1'b0;
        end else if (!rsm_ff) begin
            if (rsm_cnt_ff == RSM_LAST) begin
                nxt_rsm = 1'b1;
            end else begin
                nxt_rsm_cnt = rsm_cnt_ff + RSM_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rsm_cnt_ff <= '0;
            rsm_ff <= 1'b0;
        end else begin
            rsm_cnt_ff <= nxt_rsm_cnt;
            rsm_ff <= nxt_rsm;
        end
    end

    // ------------------------------------------------------------
    // Latched backfeed and registered combinational outputs
    // ------------------------------------------------------------
    logic cut_drive, cut_high, cut_high_d_ff, nxt_cut_high_d;
    logic slp5_d_ff, nxt_slp5_d, latch_ff, nxt_latch;
    logic nxt_flush_oe, nxt_init_oe, pg3;

    assign cut_drive = ps_good & slp3;
    assign cut_high = ~cut_drive;
    assign pg3 = fp_rst & ps_good;

    // Backfeed latch sets on cut rising, clears on S5 falling.
    // Reset leaves cut_high_d high so the power-up ramp sets nothing.
    always_comb begin
        nxt_cut_high_d = cut_high;
        nxt_slp5_d = slp5;
        nxt_latch = latch_ff;
        if (slp5_d_ff && !slp5) begin
            nxt_latch = 1'b0;
        end else if (cut_high && !cut_high_d_ff) begin
            nxt_latch = 1'b1;
        end
        nxt_flush_oe = (state_ff == SGL_FLUSH); // floats unless pulsing
        nxt_init_oe = (!init_in && state_ff != SGL_FLUSH && !gap_ff) || init_pulse_ff;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cut_high_d_ff <= 1'b1;
            slp5_d_ff <= 1'b0;
            latch_ff <= 1'b0;
            o_cpu_flush_oe <= 1'b0;
            o_firmware_hub_flush_oe <= 1'b0;
            o_init_out_oe <= 1'b0;
            o_resume_reset_out <= 1'b0;
            o_audio_reset_out <= 1'b0;
            o_audio_shutdown_out <= 1'b0;
            o_drive_activity_led_oe <= 1'b0;
            o_drive_reset_out <= 1'b0;
            o_buffered_bus_reset_out <= 1'b0;
            o_power_good_3v_out <= 1'b0;
            o_gate1_nand_out <= 1'b0;
            o_gate2_inverter_out <= 1'b0;
            o_gate3_buffer_out <= 1'b0;
            o_out_a_oe <= 1'b0;
            o_latched_backfeed_out <= 1'b0;
            o_supply_turn_on_oe <= 1'b0;
            o_clock_bias_gate_oe <= 1'b0;
            o_display_data_high_side <= 1'b0;
            o_display_clock_high_side <= 1'b0;
            o_horizontal_sync_out <= 1'b0;
            o_vertical_sync_out <= 1'b0;
            o_yellow_led_oe <= 1'b0;
            o_green_led_oe <= 1'b0;
        end else begin
            cut_high_d_ff <= nxt_cut_high_d;
            slp5_d_ff <= nxt_slp5_d;
            latch_ff <= nxt_latch;
            o_cpu_flush_oe <= nxt_flush_oe;
            o_firmware_hub_flush_oe <= nxt_flush_oe;
            o_init_out_oe <= nxt_init_oe;
            o_resume_reset_out <= nxt_rsm;
            o_audio_reset_out <= audio_enable_in & pci_rst;
            o_audio_shutdown_out <= ~mute;
            o_drive_activity_led_oe <= ~(pri_hd & sec_hd & scsi_hd);
            o_drive_reset_out <= pci_rst;
            o_buffered_bus_reset_out <= pci_rst;
            o_power_good_3v_out <= pg3;
            o_gate1_nand_out <= ~(g1a & g1b);
            o_gate2_inverter_out <= ~g2i;
            o_gate3_buffer_out <= g3i;
            o_out_a_oe <= cut_drive;
            o_latched_backfeed_out <= nxt_latch;
            o_supply_turn_on_oe <= ~slot & slp3;
            o_clock_bias_gate_oe <= pg3;
            o_display_data_high_side <= ddc_sda;
            o_display_clock_high_side <= ddc_scl;
            o_horizontal_sync_out <= hs;
            o_vertical_sync_out <= vs;
            o_yellow_led_oe <= ~(ylw_bl & slp5);
            o_green_led_oe <= ~(grn_bl & slp5);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence flush_start_s;
        state_ff == SGL_IDLE && flush_edge && wrap;
    endsequence
    sequence flush_window_s;
        (state_ff == SGL_FLUSH) [*8];
    endsequence

    flush_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        flush_start_s |=> flush_window_s)
        else $error("flush window too short");
    flush_ignored_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state_ff == SGL_IDLE && !wrap |=> state_ff == SGL_IDLE)
        else $error("flush edge taken with wrap low");
    flush_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state_ff == SGL_IDLE && $past(state_ff) == SGL_IDLE |=> !o_cpu_flush_oe)
        else $error("flush driven while idle");
    flush_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state_ff == SGL_FLUSH && $past(state_ff) == SGL_IDLE |-> ##200 state_ff == SGL_INIT)
        else $error("flush length wrong");
    init_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        state_ff == SGL_IDLE && !gap_ff && init_in && !init_pulse_ff |=> !o_init_out_oe)
        else $error("init driven while input high");
    resume_fall_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !stby |-> ##1 !o_resume_reset_out)
        else $error("resume reset not reasserted");
    audio_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_audio_reset_out == ($past(audio_enable_in) & $past(pci_rst)))
        else $error("audio reset mismatch");
    latch_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(slp5) |=> !o_latched_backfeed_out)
        else $error("latch not cleared by S5");
    led_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ylw_bl && slp5 |=> !o_yellow_led_oe)
        else $error("yellow led driven");
endmodule // sgl_glue

// file: include/sgl_pkg.sv
// Constants for the system glue logic block.
// Assumes a single 200 MHz system clock; pin clocks are sampled, not used.
package sgl_pkg;
    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_MHZ = 200;
    localparam int unsigned SYS_PERIOD_NS = 5;
    // Nominal flush interval t1 and init unit t, in nanoseconds
    localparam int unsigned T1_NS = 1000;
    localparam int unsigned TU_NS = 200;
    // Input clock rates selected by the strap
    localparam int unsigned CLK_IN_FAST_MHZ = 66;
    localparam int unsigned CLK_IN_SLOW_MHZ = 33;
    // Resume reset delay after standby supply rises
    localparam int unsigned RSM_DELAY_MS = 32;
    localparam int unsigned RSM_DELAY_CYC = RSM_DELAY_MS * 1000 * SYS_CLK_MHZ;
    // Strap level meaning 33 MHz
    localparam logic STRAP_SLOW = 1'b1;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned RSM_W = 24;

    // Flush / init pulse sequencer states
    typedef enum logic [1:0] {
        SGL_IDLE  = 2'b00,
        SGL_FLUSH = 2'b01,
        SGL_INIT  = 2'b10
    } sgl_state_t;
endpackage

// file: design/sgl_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to i_clk_sys.
`timescale 1ns/100ps
module sgl_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule // sgl_sync

// file: verification/sgl_hub_model.sv
// Partner model: hub side of the sleep-state handshake with the glue block.
// Assumes a free-running system clock; passes bench levels through while idle.
`timescale 1ns/100ps
module sgl_hub_model #(
    parameter int unsigned T3_CYC = 8000,
    parameter int unsigned T4_CYC = 200000
) (
    input wire logic i_clk_sys,
    input wire logic i_start,
    input wire logic i_s3,
    input wire logic i_s5,
    output logic o_s3,
    output logic o_s5,
    output logic o_busy
);
    // ------------------------------------------------------------
    // Sleep line sequencing
    // ------------------------------------------------------------
    logic s3_q;
    logic s5_q;
    // Sequence owns both sleep lines only while it runs
    assign o_s3 = o_busy ? s3_q : i_s3;
    assign o_s5 = o_busy ? s5_q : i_s5;
    // Second power sequence: release cut, drop S5, restore, then re-drive cut
    initial begin
        o_busy = 1'b0;
        s3_q = 1'b1;
        s5_q = 1'b1;
        forever begin
            @(posedge i_start);
            o_busy = 1'b1;
            @(negedge i_clk_sys);
            s3_q = 1'b0;
            // Cut floats about three clocks later, so this lands mid-window
            repeat (T3_CYC) @(negedge i_clk_sys);
            s5_q = 1'b0;
            repeat (200) @(negedge i_clk_sys);
            s5_q = 1'b1;
            // Cut only re-driven after the settle time
            repeat (T4_CYC) @(negedge i_clk_sys);
            s3_q = 1'b1;
            repeat (2) @(negedge i_clk_sys);
            o_busy = 1'b0;
        end
    end
endmodule // sgl_hub_model

// file: verification/sgl_glue_tb.sv
// Self-checking bench for the glue block: level scoreboard plus pulse monitor.
// Assumes the hub model drives both sleep lines; resume delay shortened to 100.
`timescale 1ns/100ps
module sgl_glue_tb;
    import sgl_pkg::*;
    // ------------------------------------------------------------
    // Constants, signals, instances
    // ------------------------------------------------------------
    localparam int unsigned RSM_SIM = 100;
    localparam int unsigned FL_CYC = T1_NS / SYS_PERIOD_NS;
    localparam int unsigned GAP_CYC = (T1_NS - TU_NS) / SYS_PERIOD_NS;
    localparam int unsigned IN_CYC = 2 * TU_NS / SYS_PERIOD_NS;
    typedef struct packed {
        logic ar, sd, led, ide, bro, pg, g1, g2, g3, cut, son, bias;
        logic dd, dc, hs, vs, yl, gl, fl, fh, io, rs, lat;
    } sgl_exp_t;
    logic i_clk_sys, i_reset_n, i_flush_request_in, i_address_wrap_in, i_init_in;
    logic i_clk_rate_strap, i_standby_5v_supply, i_audio_enable_in, i_pci_reset_in;
    logic i_mute_in, i_primary_drive_active, i_secondary_drive_active, i_scsi_drive_active;
    logic i_front_panel_reset, i_supply_power_good, i_gate1_input_a, i_gate1_input_b;
    logic i_gate2_input, i_gate3_input, i_sleep_state3, i_sleep_state5, i_slot_occupied;
    logic i_display_data_low_side, i_display_clock_low_side, i_horizontal_sync_in;
    logic i_vertical_sync_in, i_yellow_blink_in, i_green_blink_in;
    logic o_cpu_flush_oe, o_firmware_hub_flush_oe, o_init_out_oe, o_resume_reset_out;
    logic o_audio_reset_out, o_audio_shutdown_out, o_drive_activity_led_oe;
    logic o_drive_reset_out, o_buffered_bus_reset_out, o_power_good_3v_out;
    logic o_gate1_nand_out, o_gate2_inverter_out, o_gate3_buffer_out, o_out_a_oe;
    logic o_latched_backfeed_out, o_supply_turn_on_oe, o_clock_bias_gate_oe;
    logic o_display_data_high_side, o_display_clock_high_side, o_horizontal_sync_out;
    logic o_vertical_sync_out, o_yellow_led_oe, o_green_led_oe;
    logic tb_s3, tb_s5, tb_start, e_rs, e_lat, cut_prev, s5_prev, cut_now;
    logic [31:0] rnd;
    int miscompares, n_checks;
    sgl_exp_t q_e[$];
    int unsigned q_w[$];
    event ev_s;

    sgl_glue #(.RSM_CYC(RSM_SIM)) sgl_glue_inst (.*);
    sgl_hub_model #(.T3_CYC(8000), .T4_CYC(200000)) sgl_hub_model_inst (
        .i_clk_sys(i_clk_sys), .i_start(tb_start), .i_s3(tb_s3), .i_s5(tb_s5),
        .o_s3(i_sleep_state3), .o_s5(i_sleep_state5), .o_busy());

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic set_pins(input logic [23:0] v);
        {i_address_wrap_in, i_init_in, i_clk_rate_strap, i_audio_enable_in, i_pci_reset_in,
         i_mute_in, i_primary_drive_active, i_secondary_drive_active, i_scsi_drive_active,
         i_front_panel_reset, i_supply_power_good, i_gate1_input_a, i_gate1_input_b,
         i_gate2_input, i_gate3_input, tb_s3, tb_s5, i_slot_occupied,
         i_display_data_low_side, i_display_clock_low_side, i_horizontal_sync_in,
         i_vertical_sync_in, i_yellow_blink_in, i_green_blink_in} = v;
    endtask
    // Wait, note the expected levels from the pins, then wake the monitor
    task automatic snap(input int n);
        sgl_exp_t e;
        repeat (n) @(negedge i_clk_sys);
        cut_now = i_supply_power_good & i_sleep_state3;
        // Same-cycle set and clear: clear wins
        if (cut_prev & ~cut_now) e_lat = 1'b1;
        if (s5_prev & ~i_sleep_state5) e_lat = 1'b0;
        cut_prev = cut_now;
        s5_prev = i_sleep_state5;
        e = {i_audio_enable_in & i_pci_reset_in, ~i_mute_in,
             ~(i_primary_drive_active & i_secondary_drive_active & i_scsi_drive_active),
             i_pci_reset_in, i_pci_reset_in, i_front_panel_reset & i_supply_power_good,
             ~(i_gate1_input_a & i_gate1_input_b), ~i_gate2_input, i_gate3_input, cut_now,
             ~i_slot_occupied & i_sleep_state3, i_front_panel_reset & i_supply_power_good,
             i_display_data_low_side, i_display_clock_low_side, i_horizontal_sync_in,
             i_vertical_sync_in, ~(i_yellow_blink_in & i_sleep_state5),
             ~(i_green_blink_in & i_sleep_state5), 2'b00, ~i_init_in, e_rs, e_lat};
        q_e.push_back(e);
        ->ev_s;
    endtask
    // Flush request with a second edge while busy, which must be ignored
    task automatic run_flush(input logic wrap, input logic ini, input logic strap);
        i_address_wrap_in = wrap;
        i_init_in = ini;
        i_clk_rate_strap = strap;
        repeat (5) @(negedge i_clk_sys);
        if (wrap) begin
            q_w.push_back(FL_CYC);
            q_w.push_back(GAP_CYC);
            q_w.push_back(IN_CYC);
        end
        i_flush_request_in = 1'b0;
        repeat (20) @(negedge i_clk_sys);
        if (!wrap) snap(0);
        i_init_in = 1'b1;
        i_flush_request_in = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        i_flush_request_in = 1'b0;
        repeat (600) @(negedge i_clk_sys);
        i_flush_request_in = 1'b1;
    endtask
    function automatic logic [31:0] take();
        if (q_w.size() == 0) return 32'hFFFF_FFFF;
        return q_w.pop_front();
    endfunction

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    // Level scoreboard: oldest note against what the pins show now
    initial begin : level_mon
        sgl_exp_t e;
        forever begin
            @(ev_s);
            e = q_e.pop_front();
            check("audio_reset", o_audio_reset_out, e.ar);
            check("audio_shutdown", o_audio_shutdown_out, e.sd);
            check("drive_led", o_drive_activity_led_oe, e.led);
            check("drive_reset", o_drive_reset_out, e.ide);
            check("bus_reset", o_buffered_bus_reset_out, e.bro);
            check("power_good_3v", o_power_good_3v_out, e.pg);
            check("gate1", o_gate1_nand_out, e.g1);
            check("gate2", o_gate2_inverter_out, e.g2);
            check("gate3", o_gate3_buffer_out, e.g3);
            check("out_a", o_out_a_oe, e.cut);
            check("turn_on", o_supply_turn_on_oe, e.son);
            check("bias_gate", o_clock_bias_gate_oe, e.bias);
            check("ddc_data", o_display_data_high_side, e.dd);
            check("ddc_clock", o_display_clock_high_side, e.dc);
            check("hsync", o_horizontal_sync_out, e.hs);
            check("vsync", o_vertical_sync_out, e.vs);
            check("yellow_led", o_yellow_led_oe, e.yl);
            check("green_led", o_green_led_oe, e.gl);
            check("cpu_flush", o_cpu_flush_oe, e.fl);
            check("fwh_flush", o_firmware_hub_flush_oe, e.fh);
            check("init_out", o_init_out_oe, e.io);
            check("resume_reset", o_resume_reset_out, e.rs);
            check("latched_cut", o_latched_backfeed_out, e.lat);
        end
    end
    // Pulse monitor: flush width, gap to init, init width
    initial begin : pulse_mon
        int unsigned w;
        forever begin
            @(negedge i_clk_sys);
            if (o_cpu_flush_oe === 1'b1) begin
                check("fwh_flush_on", o_firmware_hub_flush_oe, 1'b1);
                for (w = 0; o_cpu_flush_oe === 1'b1 && w < 1000; w++) @(negedge i_clk_sys);
                check("flush_width", w, take());
                for (w = 0; o_init_out_oe !== 1'b1 && w < 1000; w++) @(negedge i_clk_sys);
                check("init_gap", w, take());
                for (w = 0; o_init_out_oe === 1'b1 && w < 1000; w++) @(negedge i_clk_sys);
                check("init_width", w, take());
            end
        end
    end

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // Hang guard: counts as a mismatch
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        miscompares++;
        close_out();
    end
    initial begin
        i_reset_n = 1'b0;
        set_pins(24'h000000);
        i_init_in = 1'b1;
        i_flush_request_in = 1'b1;
        i_standby_5v_supply = 1'b0;
        {tb_start, e_rs, e_lat, cut_prev, s5_prev, cut_now} = 6'h00;
        rnd = $urandom(90200);
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        snap(6);
        // Resume reset, then a brown-out that must restart the delay
        i_standby_5v_supply = 1'b1;
        snap(RSM_SIM - 5);
        e_rs = 1'b1;
        snap(15);
        i_standby_5v_supply = 1'b0;
        e_rs = 1'b0;
        snap(4);
        i_standby_5v_supply = 1'b1;
        snap(60);
        e_rs = 1'b1;
        snap(60);
        // Random levels on every combinational function
        for (int k = 0; k < 40; k++) begin
            rnd = $urandom;
            set_pins(rnd[23:0]);
            snap(6);
        end
        // Flush cases, both strap settings, wrap high and low
        for (int k = 0; k < 4; k++) run_flush(~k[1], k[0], k[0] ^ k[1]);
        // Second power sequence through the hub model
        tb_s3 = 1'b1;
        tb_s5 = 1'b1;
        i_supply_power_good = 1'b1;
        snap(6);
        tb_start = 1'b1;
        snap(20);
        tb_start = 1'b0;
        for (int k = 0; k < 10000 && i_sleep_state5 !== 1'b0; k++) @(negedge i_clk_sys);
        if (i_sleep_state5 !== 1'b0) miscompares++;
        snap(6);
        for (int k = 0; k < 1000 && i_sleep_state5 !== 1'b1; k++) @(negedge i_clk_sys);
        if (i_sleep_state5 !== 1'b1) miscompares++;
        snap(6);
        close_out();
    end
endmodule // sgl_glue_tb
